//--- hdl/mbd_defs.vh
// Purpose: Constants for the modify and branch decoder.
// Assumes: 48-bit instruction words, AHB-Lite register access.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
`ifndef MBD_DEFS_VH
`define MBD_DEFS_VH
// ******************************
// Opcode groups and fields
// ******************************
`define MBD_OP_SHIFT_MEM   4'h8
`define MBD_OP_SHIFT_ONLY  8'h02
`define MBD_OP_MODIFY      8'h04
`define MBD_OP_JMP_DIRECT  8'h06
`define MBD_OP_JMP_REL     8'h07
`define MBD_TEST_PREDICATE_TRUE      5'h1f
// ******************************
// Register map
// ******************************
`define MBD_ADDR_CTRL      12'h000
`define MBD_ADDR_INTSTAT   12'h004
`define MBD_ADDR_INTREQ    12'h008
`define MBD_ADDR_DAG_BASE  12'h100
`define MBD_CTRL_DUAL_BIT  0
`define MBD_CTRL_RESET     32'h0000_0000
`define MBD_INT_COUNT      8
`endif

//--- hdl/mbd_dag.v
// Purpose: Index, modifier, length and base registers of both
//          address generators, with post-modify and ring wrap.
// Assumes: Entry index is {kind[1:0], generator, number[2:0]}.
// Notes:   Kind 0 index, 1 modifier, 2 length, 3 base.
`timescale 1ns/1ps
module mbd_dag (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        modEn,
  input  wire        modGen,
  input  wire [2:0]  modIdx,
  input  wire [2:0]  modMod,
  output wire [31:0] idxValue,
  input  wire        busWrEn,
  input  wire [5:0]  busWrSel,
  input  wire [31:0] busWrData,
  input  wire [5:0]  busRdSel,
  output wire [31:0] busRdData
);
  reg  [31:0] regFile [0:63];
  wire [3:0]  pairSel = {modGen, modIdx};
  wire [31:0] curI    = regFile[{2'b00, pairSel}];
  wire [31:0] curM    = regFile[{2'b01, modGen, modMod}];
  wire [31:0] curL    = regFile[{2'b10, pairSel}];
  wire [31:0] curB    = regFile[{2'b11, pairSel}];
  wire [31:0] sumRaw  = curI + curM;
  reg  [31:0] sumWrap;
  integer     k;

  assign idxValue  = curI;
  assign busRdData = regFile[busRdSel];

  // Ring wrap applies whenever a length is set, enable bit or not
  always @* begin
    sumWrap = sumRaw;
    if (curL != 32'h0000_0000) begin
      if (sumRaw >= curB + curL)
        sumWrap = sumRaw - curL;
      else if (sumRaw < curB)
        sumWrap = sumRaw + curL;
    end
  end

  // Bus write is applied after the modify, so software wins a tie
  always @(posedge core_clk) begin
    if (srst) begin
      for (k = 0; k < 64; k = k + 1)
        regFile[k] <= 32'h0000_0000;
    end else begin
      if (modEn)
        regFile[{2'b00, pairSel}] <= sumWrap;
      if (busWrEn)
        regFile[busWrSel] <= busWrData;
    end
  end
endmodule

//--- hdl/mbd_decode.v
// Purpose: Decode and execute immediate shift, index modify and
//          direct or relative jump and call instructions.
// Assumes: Condition truth vectors come from flag logic on the
//          same clock; instruction word is held with instrValid.
// Notes:   All execution outputs appear one cycle after decode.
`timescale 1ns/1ps
`include "mbd_defs.vh"
module mbd_decode (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire [1:0]  hresp,
  output reg  [31:0] hrdata,
  input  wire [47:0] instrWord,
  input  wire        instrValid,
  input  wire [23:0] curPc,
  input  wire [31:0] condVecX,
  input  wire [31:0] condVecY,
  input  wire [7:0]  intRaise,
  input  wire        intEnter,
  input  wire [2:0]  intEnterNum,
  input  wire        intReturn,
  output reg         branchTake,
  output reg  [23:0] branchTarget,
  output reg         branchCall,
  output reg         deferredBranch,
  output reg         exitLoopPop,
  output reg         pcStackPop,
  output reg         shiftEnX,
  output reg         shiftEnY,
  output reg  [5:0]  shifterFunction,
  output reg  [11:0] shiftImm,
  output reg  [3:0]  shiftRn,
  output reg  [3:0]  shiftRx,
  output reg         memEnX,
  output reg         memEnY,
  output reg         memWrite,
  output reg         memProgram,
  output reg  [3:0]  memDreg,
  output reg  [31:0] memAddrX,
  output reg  [31:0] memAddrY,
  output reg         computeEnX,
  output reg         computeEnY,
  output reg  [22:0] computeField,
  output wire [7:0]  pendingIntLatch,
  output wire [7:0]  nestedMaskPointer
);
  // ******************************
  // Helpers
  // ******************************
  // Coded condition looked up in a lane's truth vector
  function condHit;
    input [4:0]  code;
    input [31:0] vec;
    begin
      condHit = (code == `MBD_TEST_PREDICATE_TRUE) ? 1'b1 : vec[code];
    end
  endfunction

  // Lowest set bit, the interrupt being serviced now
  function [7:0] lowestBit;
    input [7:0] v;
    begin
      lowestBit = v & (~v + 8'h01);
    end
  endfunction

  // ******************************
  // Register bus
  // ******************************
  reg         dualLaneMode_r;
  reg  [7:0]  pendingIntLatch_r;
  reg  [7:0]  nestedMaskPointer_r;
  reg         dataPhWr_r;
  reg  [11:0] dataPhAddr_r;
  wire        busTake = hsel & htrans[1] & hready;
  wire [31:0] dagRdData;
  wire        dagSel;
  wire        dagWr;
  reg  [31:0] rdMux;
  // Constant views, so that single fields can be taken from them
  wire [11:0] dagBase   = `MBD_ADDR_DAG_BASE;
  wire [31:0] ctrlReset = `MBD_CTRL_RESET;

  // Zero wait slave: every transfer completes with an OKAY answer
  assign hreadyout = 1'b1;
  assign hresp     = 2'b00;
  // Generator window is the one 256-byte page at the base
  assign dagSel    = (haddr[11:8] == dagBase[11:8]);
  assign dagWr     = dataPhWr_r & (dataPhAddr_r[11:8] == dagBase[11:8]);

  // Read word chosen in the address phase, held in the data phase
  always @* begin
    rdMux = 32'h0000_0000;
    if (dagSel)
      rdMux = dagRdData;
    else if (haddr[11:0] == `MBD_ADDR_CTRL)
      rdMux = {31'h0, dualLaneMode_r};
    else if (haddr[11:0] == `MBD_ADDR_INTSTAT)
      rdMux = {16'h0, nestedMaskPointer_r, pendingIntLatch_r};
  end

  // Address phase capture; writes land in the data phase
  always @(posedge core_clk) begin
    if (srst) begin
      dataPhWr_r   <= 1'b0;
      dataPhAddr_r <= 12'h000;
      hrdata       <= 32'h0000_0000;
    end else begin
      dataPhWr_r <= busTake & hwrite;
      if (busTake) begin
        dataPhAddr_r <= haddr[11:0];
        if (!hwrite)
          hrdata <= rdMux;
      end
    end
  end

  // Control word: lane mode steers lane y and branch condition handling
  always @(posedge core_clk) begin
    if (srst)
      dualLaneMode_r <= ctrlReset[`MBD_CTRL_DUAL_BIT];
    else if (dataPhWr_r && dataPhAddr_r == `MBD_ADDR_CTRL)
      dualLaneMode_r <= hwdata[`MBD_CTRL_DUAL_BIT];
  end

  // ******************************
  // Field extraction
  // ******************************
  wire [7:0]  opTop    = instrWord[47:40];
  wire        isShMem  = instrWord[47:44] == `MBD_OP_SHIFT_MEM;
  wire        isShOnly = opTop == `MBD_OP_SHIFT_ONLY;
  wire        isModify = opTop == `MBD_OP_MODIFY;
  wire        isJmpDir = opTop == `MBD_OP_JMP_DIRECT;
  wire        isJmpRel = opTop == `MBD_OP_JMP_REL;
  wire        isBranch = isJmpDir | isJmpRel;
  // Condition field sits at one place in every form decoded here
  wire [4:0]  condCode = instrWord[37:33];
  wire [3:0]  extField = isShMem ? instrWord[30:27] : instrWord[32:29];
  wire        selGen   = isShMem ? instrWord[32] : instrWord[28];
  wire [2:0]  selIdx   = isShMem ? instrWord[43:41] : instrWord[27:25];
  // Modify form carries only a two-bit modifier number
  wire [2:0]  selMod   = isShMem ? instrWord[40:38] : {1'b0, instrWord[24:23]};
  wire        callBit  = instrWord[39];
  wire        abortBit = instrWord[38];
  wire        delayBit = instrWord[26];
  wire        reuseBit = instrWord[24];
  wire [23:0] addrFld  = instrWord[23:0];

  // ******************************
  // Condition evaluation
  // ******************************
  wire hitX = condHit(condCode, condVecX);
  wire hitY = dualLaneMode_r ? condHit(condCode, condVecY) : 1'b0;
  wire laneX = instrValid & hitX;
  wire laneY = instrValid & hitY;
  // Shared address state moves if either lane asks for it
  wire anyLane  = laneX | laneY;
  // Program flow needs agreement of both lanes in dual mode
  wire bothLane = instrValid & hitX
                & (dualLaneMode_r ? hitY : 1'b1);

  // ******************************
  // Address generators
  // ******************************
  wire        dagModEn;
  wire [31:0] idxValue;
  assign dagModEn = anyLane & (isModify | isShMem);

  mbd_dag uDag (
    .core_clk  (core_clk),
    .srst      (srst),
    .modEn     (dagModEn),
    .modGen    (selGen),
    .modIdx    (selIdx),
    .modMod    (selMod),
    .idxValue  (idxValue),
    .busWrEn   (dagWr),
    .busWrSel  (dataPhAddr_r[7:2]),
    .busWrData (hwdata),
    .busRdSel  (haddr[7:2]),
    .busRdData (dagRdData)
  );

  // ******************************
  // Shift and memory outputs
  // ******************************
  // Immediate shifter operands and the memory side of the same word
  always @(posedge core_clk) begin
    if (srst) begin
      shiftEnX        <= 1'b0;
      shiftEnY        <= 1'b0;
      shifterFunction <= 6'h00;
      shiftImm        <= 12'h000;
      shiftRn         <= 4'h0;
      shiftRx         <= 4'h0;
      memEnX          <= 1'b0;
      memEnY          <= 1'b0;
      memWrite        <= 1'b0;
      memProgram      <= 1'b0;
      memDreg         <= 4'h0;
      memAddrX        <= 32'h0000_0000;
      memAddrY        <= 32'h0000_0000;
    end else begin
      shiftEnX <= laneX & (isShMem | isShOnly);
      shiftEnY <= laneY & (isShMem | isShOnly);
      memEnX   <= laneX & isShMem;
      memEnY   <= laneY & isShMem;
      // Fields move only for a presented word, never for idle bus noise
      if (instrValid & (isShMem | isShOnly)) begin
        shifterFunction <= instrWord[21:16];
        // Upper nibble is the extension field: bits 32:29, or bits 30:27 in the memory form
        shiftImm <= {extField, instrWord[15:8]};
        shiftRn  <= instrWord[7:4];
        shiftRx  <= instrWord[3:0];
      end
      if (instrValid & isShMem) begin
        memWrite   <= instrWord[31];
        memProgram <= selGen;
        memDreg    <= instrWord[26:23];
        memAddrX   <= idxValue;
        // Second lane addresses the neighbouring word
        memAddrY   <= idxValue + 32'h0000_0001;
      end
    end
  end

  // ******************************
  // Compute enables
  // ******************************
  // A zero compute field issues no compute operation; the index modify still runs
  wire computeNonEmpty = isModify & (instrWord[22:0] != 23'h000000);

  always @(posedge core_clk) begin
    if (srst) begin
      computeEnX   <= 1'b0;
      computeEnY   <= 1'b0;
      computeField <= 23'h000000;
    end else begin
      computeEnX <= laneX & computeNonEmpty;
      computeEnY <= laneY & computeNonEmpty;
      // Field holds for the compute unit until the next non-empty one
      if (instrValid & computeNonEmpty)
        computeField <= instrWord[22:0];
    end
  end

  // ******************************
  // Branch execution
  // ******************************
  wire        takeBr  = bothLane & isBranch;
  wire        isJump  = ~callBit;
  // Offset is two's complement, so a plain wrap-around add suffices
  wire [23:0] relTgt  = curPc + addrFld;
  wire [23:0] absTgt  = addrFld;

  always @(posedge core_clk) begin
    if (srst) begin
      branchTake     <= 1'b0;
      branchTarget   <= 24'h000000;
      branchCall     <= 1'b0;
      deferredBranch <= 1'b0;
      exitLoopPop    <= 1'b0;
      pcStackPop     <= 1'b0;
    end else begin
      branchTake     <= takeBr;
      branchCall     <= takeBr & callBit;
      deferredBranch <= takeBr & delayBit;
      exitLoopPop    <= takeBr & isJump & abortBit;
      pcStackPop     <= takeBr & isJump & abortBit;
      if (takeBr)
        branchTarget <= isJmpRel ? relTgt : absTgt;
    end
  end

  // ******************************
  // Interrupt latch and mask pointer
  // ******************************
  // Reuse only on a jump; the call form ignores the bit
  wire       reuseNow  = takeBr & isJump & reuseBit;
  wire [7:0] curSvc    = lowestBit(nestedMaskPointer_r);
  wire [7:0] reuseMask = reuseNow ? curSvc : 8'h00;
  wire [7:0] enterMask = intEnter ? (8'h01 << intEnterNum) : 8'h00;
  // Hardware requests for routines already running are dropped; software requests still latch
  wire [7:0] raiseOk   = intRaise & ~(nestedMaskPointer_r & ~reuseMask);
  wire [7:0] swRaise;
  assign swRaise = (dataPhWr_r && dataPhAddr_r == `MBD_ADDR_INTREQ) ?
                   hwdata[7:0] : 8'h00;

  // New raise beats a clear arriving in the same cycle
  always @(posedge core_clk) begin
    if (srst) begin
      pendingIntLatch_r   <= 8'h00;
      nestedMaskPointer_r <= 8'h00;
    end else begin
      pendingIntLatch_r <= (pendingIntLatch_r & ~reuseMask & ~enterMask)
                         | raiseOk | swRaise;
      nestedMaskPointer_r <= intReturn ?
        ((nestedMaskPointer_r & ~reuseMask) & ~curSvc) | enterMask :
        (nestedMaskPointer_r & ~reuseMask) | enterMask;
    end
  end

  assign pendingIntLatch   = pendingIntLatch_r;
  assign nestedMaskPointer = nestedMaskPointer_r;
endmodule

//--- sim/mbd_prog_mem.sv
// Purpose: Program memory model feeding instruction words.
// Assumes: Bench presents one word per fetch request.
// Notes:   The word bus is scrambled while no word is valid.
`timescale 1ns/1ps
// ****************
// Fetch register
// ****************
module mbd_prog_mem (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        fetchEn,
  input  wire [47:0] fetchWord,
  input  wire [23:0] fetchPc,
  output reg  [47:0] instrWord,
  output reg         instrValid,
  output reg  [23:0] curPc
);
  // Inverting the idle word hides stale data from the decoder
  always @(posedge core_clk) begin
    instrValid <= fetchEn & ~srst;
    curPc <= fetchPc;
    if (fetchEn) begin
      instrWord <= fetchWord;
    end else begin
      instrWord <= ~instrWord;
    end
  end
endmodule

//--- sim/mbd_decode_sva.sv
// Purpose: Port checks of the decoder.
// Assumes: Condition code 5'h1f is always true.
// Notes:   Taken-branch checks need both lanes true, so any mode fits.
`timescale 1ns/1ps
// ****************
// Checker
// ****************
module mbd_decode_sva (
  input wire        core_clk,
  input wire        srst,
  input wire        hreadyout,
  input wire [1:0]  hresp,
  input wire [47:0] instrWord,
  input wire        instrValid,
  input wire [23:0] curPc,
  input wire [31:0] condVecX,
  input wire [31:0] condVecY,
  input wire        branchTake,
  input wire [23:0] branchTarget,
  input wire        branchCall,
  input wire        deferredBranch,
  input wire        exitLoopPop,
  input wire        pcStackPop,
  input wire        shiftEnX,
  input wire [5:0]  shifterFunction,
  input wire [11:0] shiftImm,
  input wire        memEnX,
  input wire        memWrite,
  input wire        memProgram,
  input wire        computeEnX
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Lane truth of the coded condition
  wire [4:0] tc = instrWord[37:33];
  wire [7:0] op = instrWord[47:40];
  wire       tx = (tc == 5'h1f) | condVecX[tc];
  wire       tb = tx & ((tc == 5'h1f) | condVecY[tc]);
  wire       br = instrValid & (instrWord[47:41] == 7'h03);
  a_bus_okay: assert property (hreadyout && hresp == 2'h0)
    else $error("bus answer not ready okay");
  a_direct_take: assert property (instrValid && op == 8'h06 && tb
    |=> branchTake && branchTarget == $past(instrWord[23:0]))
    else $error("direct branch wrong");
  a_rel_target: assert property (instrValid && op == 8'h07 && tb
    |=> branchTarget == $past(curPc + instrWord[23:0]))
    else $error("relative target wrong");
  a_false_skip: assert property (br && !tx
    |=> !branchTake && !branchCall) else $error("false branch taken");
  a_loop_exit: assert property (br && tb
    && instrWord[39:38] == 2'h1 |=> exitLoopPop && pcStackPop)
    else $error("loop exit missing");
  a_call_flags: assert property (br && instrWord[39]
    |=> !exitLoopPop && !pcStackPop) else $error("call popped stacks");
  a_defer_bit: assert property (br && tb
    |=> deferredBranch == $past(instrWord[26])
        && branchCall == $past(instrWord[39])) else $error("branch kind");
  a_shift_imm: assert property (instrValid && op == 8'h02 && tx
    |=> shiftEnX && shiftImm == $past({instrWord[32:29], instrWord[15:8]})
        && shifterFunction == $past(instrWord[21:16]))
    else $error("shift fields wrong");
  a_mem_dir: assert property (instrValid && op[7:4] == 4'h8 && tx
    |=> memEnX && memWrite == $past(instrWord[31])
        && memProgram == $past(instrWord[32])) else $error("memory access");
  a_compute_nop: assert property (instrValid && op == 8'h04
    && instrWord[22:0] == 23'h0 |=> !computeEnX) else $error("empty compute");
endmodule

//--- sim/mbd_decode_bench.sv
// Purpose: Self-checking bench of the decoder.
// Assumes: Zero wait AHB-Lite slave, words fed by program memory.
// Notes:   Outputs are checked in the cycle after decode.
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module mbd_decode_bench;
  reg         core_clk = 1'b0;
  reg         srst = 1'b1;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         fetchEn = 1'b0;
  reg  [47:0] fetchWord = 48'h0;
  reg  [23:0] fetchPc = 24'h0;
  reg  [31:0] condVecX = 32'h0;
  reg  [31:0] condVecY = 32'h0;
  reg  [7:0]  intRaise = 8'h0;
  reg         intEnter = 1'b0;
  reg  [2:0]  intEnterNum = 3'h0;
  reg         intReturn = 1'b0;
  integer     failures = 0;
  integer     samples_checked = 0;
  integer     cycles = 0;
  wire        hreadyout;
  wire [31:0] hrdata;
  wire [47:0] instrWord;
  wire        instrValid;
  wire [23:0] curPc;
  wire [23:0] bTgt;
  wire [11:0] sImm;
  wire [5:0]  sFn;
  wire [31:0] mAddr;
  wire [7:0]  iLat;
  wire [7:0]  iMsk;
  wire        bT, bC, bD, bL, bP, sX, mX, mW, mP, cX, cY;
  wire [3:0]  sRn, sRx, mD;
  wire [31:0] mAy;
  wire [22:0] cF;
  wire        sY, mY;
  // Single slave: its ready is the bus ready
  mbd_decode dut (.core_clk(core_clk), .srst(srst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(), .hrdata(hrdata), .instrWord(instrWord),
    .instrValid(instrValid), .curPc(curPc), .condVecX(condVecX),
    .condVecY(condVecY), .intRaise(intRaise), .intEnter(intEnter),
    .intEnterNum(intEnterNum), .intReturn(intReturn), .branchTake(bT),
    .branchTarget(bTgt), .branchCall(bC), .deferredBranch(bD),
    .exitLoopPop(bL), .pcStackPop(bP), .shiftEnX(sX), .shiftEnY(sY),
    .shifterFunction(sFn), .shiftImm(sImm), .shiftRn(sRn),
    .shiftRx(sRx), .memEnX(mX), .memEnY(mY), .memWrite(mW),
    .memProgram(mP), .memDreg(mD), .memAddrX(mAddr), .memAddrY(mAy),
    .computeEnX(cX), .computeEnY(cY), .computeField(cF),
    .pendingIntLatch(iLat),
    .nestedMaskPointer(iMsk));
  mbd_prog_mem pm (.core_clk(core_clk), .srst(srst), .fetchEn(fetchEn),
    .fetchWord(fetchWord), .fetchPc(fetchPc), .instrWord(instrWord),
    .instrValid(instrValid), .curPc(curPc));
  always #25 core_clk = ~core_clk;
  // Hang guard, far above the length of the sequence
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      wrap_up;
    end
  end
  task wrap_up;
    begin
      if (failures == 0 && samples_checked > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Address phase held to a ready edge, then data phase to the next
  task bus(input wr, input [31:0] a, input [31:0] d, output [31:0] q);
    begin
      @(posedge core_clk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      q = hrdata;
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    reg [31:0] q;
    begin
      bus(1'b1, a, d, q);
    end
  endtask
  task rd(input [31:0] a, input [31:0] e);
    reg [31:0] q;
    begin
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
    end
  endtask
  task issue(input [47:0] w, input [23:0] pc);
    begin
      @(posedge core_clk);
      fetchWord <= w;
      fetchPc <= pc;
      fetchEn <= 1'b1;
      @(posedge core_clk);
      fetchEn <= 1'b0;
      @(posedge core_clk);
      #1;
    end
  endtask
  task irq(input [7:0] r, input e, input [2:0] n, input t);
    begin
      @(posedge core_clk);
      intRaise <= r;
      intEnter <= e;
      intEnterNum <= n;
      intReturn <= t;
      @(posedge core_clk);
      intRaise <= 8'h0;
      intEnter <= 1'b0;
      intReturn <= 1'b0;
      @(posedge core_clk);
      #1;
    end
  endtask
  function [31:0] dag(input [1:0] k, input g, input [2:0] n);
    dag = 32'h100 + {24'h0, k, g, n, 2'h0};
  endfunction
  function [47:0] fMod(input [4:0] c, input g, input [2:0] i,
                       input [1:0] m, input [22:0] cp);
    fMod = {8'h04, 2'h0, c, 4'h0, g, i, m, cp};
  endfunction
  function [47:0] fBr(input r, input b, input a, input j, input ci,
                      input [4:0] c, input [23:0] ad);
    fBr = {7'h03, r, b, a, c, 6'h0, j, 1'b0, ci, ad};
  endfunction
  function [47:0] fShm(input g, input d, input [2:0] i, input [2:0] m);
    fShm = {4'h8, i, m, 5'h1f, g, d, 8'h01, 1'b0, 6'h01, 16'h0200};
  endfunction
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    rd(32'h0, 32'h0);
    wr(32'hff0, 32'h5a);
    rd(32'hff0, 32'h0);
    wr(dag(0, 0, 2), 32'h100);
    wr(dag(1, 0, 1), 32'h10);
    wr(dag(0, 1, 2), 32'h200);
    wr(dag(1, 1, 1), 32'h4);
    issue(fMod(5'h1f, 0, 2, 1, 0), 0);
    chk(cX, 0);
    rd(dag(0, 0, 2), 32'h110);
    issue(fMod(5'h1f, 1, 2, 1, 0), 0);
    rd(dag(0, 1, 2), 32'h204);
    rd(dag(0, 0, 2), 32'h110);
    // Ring of 0x20 bytes at 0x1000: 0x101c + 8 wraps to 0x1004
    wr(dag(2, 0, 3), 32'h20);
    wr(dag(3, 0, 3), 32'h1000);
    wr(dag(0, 0, 3), 32'h101c);
    wr(dag(1, 0, 2), 32'h8);
    issue(fMod(5'h1f, 0, 3, 2, 0), 0);
    rd(dag(0, 0, 3), 32'h1004);
    issue(fMod(5'h03, 0, 2, 1, 23'h1), 0);
    chk(cX, 0);
    rd(dag(0, 0, 2), 32'h110);
    // Dual lane: only lane y true
    wr(32'h0, 32'h1);
    condVecY <= 32'h8;
    issue(fMod(5'h03, 0, 2, 1, 23'h1), 0);
    chk({cX, cY}, 2'b01);
    rd(dag(0, 0, 2), 32'h120);
    condVecX <= 32'h10;
    condVecY <= 32'h0;
    issue(fBr(0, 0, 0, 0, 0, 5'h04, 24'h1234), 0);
    chk(bT, 0);
    condVecY <= 32'h10;
    issue(fBr(0, 0, 0, 0, 0, 5'h04, 24'h1234), 0);
    chk({bT, bTgt}, {1'b1, 24'h1234});
    // Both lanes true: both compute, one modify of index 3, generator 1
    issue(fMod(5'h04, 1, 3, 1, 23'h7), 0);
    chk({cX, cY, cF}, {2'b11, 23'h7});
    rd(dag(0, 1, 3), 32'h4);
    wr(32'h0, 32'h0);
    issue(fBr(1, 0, 0, 0, 0, 5'h1f, 24'hfffff0), 24'h100);
    chk({bT, bTgt}, {1'b1, 24'h0000f0});
    issue(fBr(0, 0, 1, 1, 0, 5'h1f, 24'h0abcde), 0);
    chk({bT, bC, bD, bL, bP}, 5'b10111);
    issue(fBr(0, 1, 1, 0, 1, 5'h1f, 24'h0abcde), 0);
    chk({bT, bC, bD, bL, bP}, 5'b11000);
    condVecX <= 32'h0;
    issue(fBr(0, 0, 0, 0, 0, 5'h04, 24'h1234), 0);
    chk(bT, 0);
    issue({8'h02, 2'h0, 5'h1f, 4'ha, 7'h0, 6'h05, 8'h3c, 8'h5a}, 0);
    chk({sX, sY, sImm}, {2'b10, 12'ha3c});
    chk(sFn, 6'h05);
    chk({sRn, sRx}, 8'h5a);
    issue(fShm(0, 1, 2, 1), 0);
    chk({mX, mW, mP, mAddr}, {3'b110, 32'h120});
    chk({mY, mD, mAy}, {1'b0, 4'h1, 32'h121});
    rd(dag(0, 0, 2), 32'h130);
    issue(fShm(1, 0, 2, 1), 0);
    chk({mX, mW, mP, mAddr}, {3'b101, 32'h204});
    // Interrupt 2 in service, then reused by a clearing jump
    irq(8'h0, 1, 2, 0);
    irq(8'h04, 0, 0, 0);
    chk({iMsk, iLat}, 16'h0400);
    // Software sets the latch bit so that the clear has work to do
    wr(32'h8, 32'h4);
    rd(32'h4, 32'h0404);
    issue(fBr(0, 0, 0, 0, 1, 5'h1f, 24'h10), 0);
    chk({iMsk, iLat}, 16'h0000);
    irq(8'h04, 0, 0, 0);
    chk(iLat, 8'h04);
    wr(32'h8, 32'h20);
    irq(8'h0, 1, 3, 0);
    irq(8'h0, 0, 0, 1);
    rd(32'h4, 32'h24);
    wrap_up;
  end
endmodule
bind mbd_decode mbd_decode_sva chk_i (.core_clk(core_clk), .srst(srst),
  .hreadyout(hreadyout), .hresp(hresp), .instrWord(instrWord),
  .instrValid(instrValid), .curPc(curPc), .condVecX(condVecX),
  .condVecY(condVecY), .branchTake(branchTake),
  .branchTarget(branchTarget), .branchCall(branchCall),
  .deferredBranch(deferredBranch), .exitLoopPop(exitLoopPop),
  .pcStackPop(pcStackPop), .shiftEnX(shiftEnX),
  .shifterFunction(shifterFunction), .shiftImm(shiftImm),
  .memEnX(memEnX), .memWrite(memWrite), .memProgram(memProgram),
  .computeEnX(computeEnX));
